/* rtl/rbc_bit_cell.sv */
// Purpose: one register bit with a selectable access behaviour
// Assumes: strobes are one-cycle pulses on clk, event inputs synchronous
// Notes:   hardware set wins over a host or read clear in the same cycle, except on a self-setting bit; lite and soft resets win over it
`timescale 1ns/1ps
module rbc_bit_cell #(
  parameter rbc_pkg::rbc_access_e ACCESS     = rbc_pkg::RBC_RW,
  parameter logic                 RESET_BIT  = 1'b0,
  parameter logic                 KEEP_LITE  = 1'b0,
  parameter logic                 KEEP_SOFT  = 1'b0
) (
  // clock and resets
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic lite_reset,
  input  wire logic soft_reset,
  // access strobes
  input  wire logic rd_done,
  input  wire logic wr_en,
  input  wire logic wr_bit,
  // hardware side
  input  wire logic hw_cond,
  input  wire logic hw_clear,
  // state
  output logic      bit_q,
  output logic      rd_bit
);

  typedef struct packed {
    logic val;
    logic armed;
  } rbc_cell_s;

  rbc_cell_s st_q;
  rbc_cell_s st_d;

  always_comb begin
    st_d = st_q;
    case (ACCESS)
      rbc_pkg::RBC_RW: begin
        if (wr_en) st_d.val = wr_bit;
      end
      rbc_pkg::RBC_RO: begin
        st_d.val = hw_cond; // [R1]
      end
      rbc_pkg::RBC_READ_TO_SET: begin
        if (wr_en) st_d.val = wr_bit;
        if (rd_done) st_d.val = 1'b1; // [R2] [R16]
      end
      rbc_pkg::RBC_READ_THEN_CLEAR: begin
        if (rd_done) st_d.val = 1'b0; // [R3] [R16]
        if (hw_cond) st_d.val = 1'b1;
      end
      rbc_pkg::RBC_WO: begin
        if (wr_en) st_d.val = wr_bit; // [R4]
      end
      rbc_pkg::RBC_WRITE_ONE_CLEAR: begin
        if (wr_en && wr_bit) st_d.val = 1'b0; // [R5]
        if (hw_cond) st_d.val = 1'b1;
      end
      rbc_pkg::RBC_WRITE_ANY_CLEAR: begin
        if (wr_en) st_d.val = 1'b0; // [R6]
        if (hw_cond) st_d.val = 1'b1;
      end
      rbc_pkg::RBC_LATCH_LOW_CLEAR: begin
        // active-low latch: idles high, holds a low event
        if (rd_done) st_d.val = 1'b1; // [R7] [R16]
        if (!hw_cond) st_d.val = 1'b0; // [R7]
      end
      rbc_pkg::RBC_LATCH_HIGH_CLEAR: begin
        if (rd_done) st_d.val = 1'b0; // [R8] [R16]
        if (hw_cond) st_d.val = 1'b1; // [R8]
      end
      rbc_pkg::RBC_SELF_CLEARING: begin
        if (st_q.val && hw_clear) st_d.val = 1'b0; // [R9]
        if (wr_en && wr_bit) st_d.val = 1'b1; // [R9]
      end
      rbc_pkg::RBC_SELF_SETTING: begin
        // a host clear of a set bit wins; self-set acts only on a bit already at zero
        if (wr_en && !wr_bit) st_d.val = 1'b0; // [R10]
        if (!st_q.val && hw_clear) st_d.val = 1'b1; // [R10]
      end
      rbc_pkg::RBC_STICKY_HIGH_STATUS: begin
        // armed once read: then the bit follows the condition
        if (rd_done) st_d.armed = 1'b1; // [R12] [R16]
        if (st_d.armed) st_d.val = hw_cond; // [R12]
        if (hw_cond) st_d.val = 1'b1; // [R11]
        if (!st_d.val) st_d.armed = 1'b0; // [R12]
      end
      default: begin
        st_d.val = 1'b0;
      end
    endcase
    if ((lite_reset && !KEEP_LITE) || (soft_reset && !KEEP_SOFT)) begin
      st_d.val   = RESET_BIT; // [R13] [R14]
      st_d.armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_q <= '{val: RESET_BIT, armed: 1'b0};
    else          st_q <= st_d;
  end

  assign bit_q  = st_q.val;
  assign rd_bit = (ACCESS == rbc_pkg::RBC_WO || ACCESS == rbc_pkg::RBC_RESERVED)
                  ? rbc_pkg::HIDDEN_READ : st_q.val; // [R4] [R15]

endmodule : rbc_bit_cell

/* rtl/rbc_pkg.sv */
// Purpose: shared constants and types for the register bit access cells
// Assumes: one 32-bit register built from per-bit access types
// Notes:   access type of each bit is a fixed code taken at elaboration
package rbc_pkg;

  localparam int unsigned DATA_W = 32;

  typedef enum logic [3:0] {
    RBC_RW                 = 4'h0,
    RBC_RO                 = 4'h1,
    RBC_READ_TO_SET        = 4'h2,
    RBC_READ_THEN_CLEAR    = 4'h3,
    RBC_WO                 = 4'h4,
    RBC_WRITE_ONE_CLEAR    = 4'h5,
    RBC_WRITE_ANY_CLEAR    = 4'h6,
    RBC_LATCH_LOW_CLEAR    = 4'h7,
    RBC_LATCH_HIGH_CLEAR   = 4'h8,
    RBC_SELF_CLEARING      = 4'h9,
    RBC_SELF_SETTING       = 4'hA,
    RBC_STICKY_HIGH_STATUS = 4'hB,
    RBC_RESERVED           = 4'hC
  } rbc_access_e;

  // reset value of every bit, lite and soft reset defaults
  localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
  // value a write-only or reserved bit shows on read
  localparam logic               HIDDEN_READ = 1'b0;

endpackage : rbc_pkg

/* rtl/rbc_reg.sv */
// Purpose: one 32-bit register built from per-bit access cells
// Assumes: host access port on clk; rd_done pulses when a read completes
// Notes:   read data is registered on the read request
//
// How it works
// R1: read-only bits show their live value, writes ignored.
// R2: read-to-set bits become one when read.
// R3: read-then-clear bits return value, clear after the read, ignore writes.
// R4: write-only bits accept writes; reads return a fixed hidden value.
// R5: writing one clears a write-one-clear bit; zero leaves it.
// R6: any write clears a write-any-clear bit.
// R7: latch-low bits hold a low event until the register is read.
// R8: latch-high bits hold a high event until the register is read.
// R9: self-clearing bits drop to zero by themselves; writing zero does nothing.
// R10: self-setting bits return to one by themselves; writing one does nothing.
// R11: sticky-high status holds high after the condition until read.
// R12: after its read, sticky-high follows the condition.
// R13: bits marked keep-on-lite-reset survive a lite reset.
// R14: bits marked keep-on-soft-reset survive a software reset.
// R15: host writes zero to reserved bits; their read value is not guaranteed.
// R16: read side effects only on a completed host read of this register.
`timescale 1ns/1ps
module rbc_reg #(
  parameter rbc_pkg::rbc_access_e ACCESS [rbc_pkg::DATA_W] = '{default: rbc_pkg::RBC_RW},
  parameter logic [rbc_pkg::DATA_W-1:0] KEEP_LITE = '0,
  parameter logic [rbc_pkg::DATA_W-1:0] KEEP_SOFT = '0
) (
  // clock and resets
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       lite_reset,
  input  wire logic                       soft_reset,
  // host access
  input  wire logic                       sel,
  input  wire logic                       rd_req,
  input  wire logic                       rd_done,
  input  wire logic                       wr_req,
  input  wire logic [rbc_pkg::DATA_W-1:0] wr_data,
  output logic      [rbc_pkg::DATA_W-1:0] rd_data,
  // hardware side
  input  wire logic [rbc_pkg::DATA_W-1:0] hw_cond,
  input  wire logic [rbc_pkg::DATA_W-1:0] hw_clear,
  output logic      [rbc_pkg::DATA_W-1:0] value
);

  typedef struct packed {
    logic [rbc_pkg::DATA_W-1:0] rdata;
  } rbc_reg_s;

  rbc_reg_s                   st_q;
  rbc_reg_s                   st_d;
  logic [rbc_pkg::DATA_W-1:0] rd_bits;
  logic                       rd_hit;
  logic                       wr_hit;

  assign rd_hit = sel && rd_done; // [R16]
  assign wr_hit = sel && wr_req;

  ////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < rbc_pkg::DATA_W; i++) begin : g_bit
    rbc_bit_cell #(
      .ACCESS    (ACCESS[i]),
      .RESET_BIT (rbc_pkg::RESET_VALUE[i]),
      .KEEP_LITE (KEEP_LITE[i]), // [R13]
      .KEEP_SOFT (KEEP_SOFT[i])  // [R14]
    ) u_cell (
      .clk        (clk),
      .reset_n    (reset_n),
      .lite_reset (lite_reset),
      .soft_reset (soft_reset),
      .rd_done    (rd_hit),
      .wr_en      (wr_hit),
      .wr_bit     (wr_data[i]),
      .hw_cond    (hw_cond[i]),
      .hw_clear   (hw_clear[i]),
      .bit_q      (value[i]),
      .rd_bit     (rd_bits[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    if (sel && rd_req) st_d.rdata = rd_bits;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_q <= '0;
    else          st_q <= st_d;
  end

  assign rd_data = st_q.rdata;

endmodule : rbc_reg

/* tb/rbc_host.sv */
// Purpose: host model issuing register accesses
// Assumes: one access at a time
// Notes:   released write data inverted
`timescale 1ns/1ps
module rbc_host (
  // access port
  input  wire logic        clk,
  input  wire logic [31:0] rd_data,
  output logic             sel,
  output logic             rd_req,
  output logic             rd_done,
  output logic             wr_req,
  output logic      [31:0] wr_data
);
  initial {sel, rd_req, rd_done, wr_req, wr_data} = 36'h0;
  task automatic wr(input logic [31:0] d);
    @(posedge clk);
    {sel, wr_req} <= 2'h3;
    wr_data <= d & 32'hFFFF_F7FF;
    @(posedge clk);
    {sel, wr_req} <= 2'h0;
    wr_data <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic s, output logic [31:0] d);
    @(posedge clk);
    {sel, rd_req, rd_done} <= {s, 2'h3};
    @(posedge clk);
    {sel, rd_req, rd_done} <= 3'h0;
    #1 d = rd_data;
  endtask : rd
endmodule : rbc_host

/* tb/rbc_reg_assertions.sv */
// Purpose: port checks for rbc_reg
// Assumes: bit map of tb_top
// Notes:   one clock domain
`timescale 1ns/1ps
module rbc_reg_checker (
  // watched ports
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        lite_reset,
  input wire logic        soft_reset,
  input wire logic        sel,
  input wire logic        rd_done,
  input wire logic        wr_req,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] hw_cond,
  input wire logic [31:0] value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || lite_reset || soft_reset);
  wire rd_hit = sel && rd_done;
  wire wr_hit = sel && wr_req;
  // sticky bit read since it last went high
  logic read_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)         read_q <= 1'b0;
    else if (rd_hit)      read_q <= 1'b1;
    else if (!value[10])  read_q <= 1'b0;
  end
  chk_ro_no_write: assert property (wr_hit && wr_data[0] && !hw_cond[0] ##1 !hw_cond[0] |-> !value[0])
    else $error("ro bit took a write");
  chk_read_sets: assert property (rd_hit |=> value[1]) else $error("rs bit not set");
  chk_read_clears: assert property (rd_hit && !hw_cond[2] |=> !value[2]) else $error("rc bit kept");
  chk_one_clears: assert property (wr_hit && wr_data[4] && !hw_cond[4] |=> !value[4]) else $error("w1c kept");
  chk_any_clears: assert property (wr_hit && !hw_cond[5] |=> !value[5]) else $error("wac bit kept");
  chk_high_holds: assert property (value[7] && !rd_hit |=> value[7]) else $error("latch high lost");
  chk_sticky_holds: assert property (value[10] && !rd_hit && !read_q |=> value[10]) else $error("sticky lost");
  chk_sticky_follows: assert property (read_q && !rd_hit && !hw_cond[10] |=> !value[10])
    else $error("sticky did not follow condition");
  chk_lite_keeps: assert property (disable iff (!reset_n) lite_reset && !soft_reset && !wr_req |=>
    $stable(value[12])) else $error("kept bit lost on lite reset");
endmodule : rbc_reg_checker

/* tb/tb_top.sv */
// Purpose: bench for rbc_reg
// Assumes: bit map in MAP
// Notes:   hw side driven here
`timescale 1ns/1ps
module tb_top;
  localparam rbc_pkg::rbc_access_e MAP [rbc_pkg::DATA_W] = '{0: rbc_pkg::RBC_RO, 1: rbc_pkg::RBC_READ_TO_SET,
    2: rbc_pkg::RBC_READ_THEN_CLEAR, 3: rbc_pkg::RBC_WO, 4: rbc_pkg::RBC_WRITE_ONE_CLEAR,
    5: rbc_pkg::RBC_WRITE_ANY_CLEAR,
    6: rbc_pkg::RBC_LATCH_LOW_CLEAR, 7: rbc_pkg::RBC_LATCH_HIGH_CLEAR, 8: rbc_pkg::RBC_SELF_CLEARING,
    9: rbc_pkg::RBC_SELF_SETTING, 10: rbc_pkg::RBC_STICKY_HIGH_STATUS, 11: rbc_pkg::RBC_RESERVED,
    default: rbc_pkg::RBC_RW};
  logic clk, reset_n, lite_reset, soft_reset;
  logic sel, rd_req, rd_done, wr_req;
  logic [31:0] hw_cond, hw_clear, wr_data, rd_data, value, d;
  int mismatches = 0, compares = 0;
  always #20 clk = ~clk;
  rbc_reg #(.ACCESS(MAP), .KEEP_LITE(32'h0000_1000), .KEEP_SOFT(32'h0000_2000)) i_rbc_reg (.clk(clk),
    .reset_n(reset_n), .lite_reset(lite_reset), .soft_reset(soft_reset), .sel(sel), .rd_req(rd_req),
    .rd_done(rd_done), .wr_req(wr_req), .wr_data(wr_data), .rd_data(rd_data), .hw_cond(hw_cond),
    .hw_clear(hw_clear), .value(value));
  rbc_host i_rbc_host (.clk(clk), .rd_data(rd_data), .sel(sel), .rd_req(rd_req), .rd_done(rd_done),
    .wr_req(wr_req), .wr_data(wr_data));
  task automatic chk(input logic [31:0] got, exp, msk);
    compares++;
    if ((got & msk) !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got & msk, exp);
    end
  endtask : chk
  task automatic hw(input logic [31:0] c, clr);
    @(posedge clk);
    hw_cond <= c;
    hw_clear <= clr;
    @(posedge clk);
    hw_clear <= 32'h0;
    #1;
  endtask : hw
  task automatic rst(input logic l);
    @(posedge clk);
    lite_reset <= l;
    soft_reset <= !l;
    @(posedge clk);
    {lite_reset, soft_reset} <= 2'h0;
    #1;
  endtask : rst
  task automatic t_reads;
    hw(32'h485, 32'h0);
    hw(32'h041, 32'h0);
    i_rbc_host.rd(1'b0, d);
    chk(value, 32'h004, 32'h006);
    i_rbc_host.wr(32'h0);
    i_rbc_host.rd(1'b1, d);
    chk(d, 32'h485, 32'h4D7);
    chk(value, 32'h043, 32'h4C7);
    hw(32'h001, 32'h0);
    hw(32'h041, 32'h0);
    chk(value, 32'h000, 32'h040);
    hw(32'h441, 32'h0);
    i_rbc_host.rd(1'b1, d);
    chk(value, 32'h400, 32'h400);
    hw(32'h041, 32'h0);
    chk(value, 32'h000, 32'h400);
  endtask : t_reads
  task automatic t_clears;
    hw(32'h031, 32'h0);
    hw(32'h000, 32'h0);
    i_rbc_host.wr(32'h001);
    chk(value, 32'h010, 32'h031);
    i_rbc_host.wr(32'h010);
    chk(value, 32'h000, 32'h010);
    i_rbc_host.wr(32'h100);
    i_rbc_host.wr(32'h000);
    chk(value, 32'h100, 32'h300);
    hw(32'h000, 32'h300);
    chk(value, 32'h200, 32'h300);
    i_rbc_host.wr(32'h008);
    chk(value, 32'h008, 32'h208);
    i_rbc_host.wr(32'h208);
    chk(value, 32'h008, 32'h208);
    i_rbc_host.rd(1'b1, d);
    chk(d, {20'h0, rbc_pkg::HIDDEN_READ, 7'h0, rbc_pkg::HIDDEN_READ, 3'h0}, 32'h808);
  endtask : t_clears
  task automatic t_keep;
    i_rbc_host.wr(32'h7000);
    rst(1'b1);
    chk(value, 32'h1000, 32'h7000);
    i_rbc_host.wr(32'h7000);
    rst(1'b0);
    chk(value, 32'h2000, 32'h7000);
  endtask : t_keep
  task automatic results;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    {reset_n, lite_reset, soft_reset} <= 3'h0;
    hw_cond <= 32'h0;
    hw_clear <= 32'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reads();
    t_clears();
    t_keep();
    results();
  end
endmodule : tb_top
bind rbc_reg rbc_reg_checker i_chk (.clk(clk), .reset_n(reset_n), .lite_reset(lite_reset), .soft_reset(soft_reset),
  .sel(sel), .rd_done(rd_done), .wr_req(wr_req), .wr_data(wr_data), .hw_cond(hw_cond), .value(value));
